// *** rtl/slpmc_top.sv ***
// sleep mode and peripheral clock gating controller with apb registers
// Contract
// [RULE1] five sleep modes, entered when the core runs the sleep instruction
// [RULE2] sleep may be entered only from active mode
// [RULE3] core fetch halts in sleep until allowed interrupt or reset
// [RULE4] the configured mode selects which interrupts may wake
// [RULE5] interrupt wake runs the handler then resumes after sleep
// [RULE6] pending higher priority interrupts are served first in order
// [RULE7] core stalls four clock cycles after any wake-up; here only interrupt wakes stall, reset wake resumes at once
// [RULE8] register file, memory and peripheral registers are kept in sleep
// [RULE9] reset during sleep restarts from the reset vector
// [RULE10] enabled reset sources also wake the device
// [RULE11] idle stops core and memory clocks; programming finishes first
// [RULE12] idle keeps peripherals and interrupt controller running
// [RULE13] power-down stops every clock including real-time counter; here the memory clock keeps running while NVM_BUSY_IN is high
// [RULE14] power-down wakes only on address match, async port, usb resume
// [RULE15] power reduction bits gate a peripheral clock, freezing it
// [RULE16] peripheral gating applies in active and idle modes
// [RULE17] mode taken from software setting when sleep instruction runs
// [RULE18] other modes parameterised, defaulting to power-down behaviour
module slpmc_top #(
    parameter int NUM_PERIPH = 16,
    parameter logic [7:0] PSAVE_WAKE = slpmc_pkg::PDOWN_WAKE_SET,
    parameter logic [7:0] STDBY_WAKE = slpmc_pkg::PDOWN_WAKE_SET,
    parameter logic [7:0] ESTDBY_WAKE = slpmc_pkg::PDOWN_WAKE_SET,
    parameter bit PSAVE_RTC_RUN = 1'b0,
    parameter bit ESTDBY_RTC_RUN = 1'b0
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // core side
    input wire logic SLEEP_INSTR_IN,
    input wire logic NVM_BUSY_IN,
    output logic CORE_HALT_OUT,
    // wake sources (asynchronous)
    input wire logic [7:0] WAKE_IRQ_IN,
    input wire logic RESET_REQ_IN,
    // clock enables and restart pulse
    output logic CORE_CLK_EN_OUT,
    output logic NVM_CLK_EN_OUT,
    output logic PERIPH_CLK_EN_OUT,
    output logic RTC_CLK_EN_OUT,
    output logic [NUM_PERIPH-1:0] PERIPH_GATE_EN_OUT,
    output logic SYS_RESET_OUT,
    // interrupt
    output logic IRQ_OUT
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    slpmc_pkg::slpmc_state_e state;
    logic sleep_enable;
    logic [2:0] mode_sel;
    logic [2:0] active_mode;
    logic [NUM_PERIPH-1:0] pwr_red;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] wake_en;
    logic [2:0] halt_cnt;
    logic [7:0] wake_sync1;
    logic [7:0] wake_sync2;
    logic rst_sync1;
    logic rst_sync2;
    logic wr_stb;
    logic rd_setup;
    logic wr_ctrl;
    logic wr_pwr_red;
    logic wr_irq_mask;
    logic wr_wake_en;
    logic wr_irq_status;
    logic addr_ok;
    logic [7:0] allowed;
    logic wake_hit;
    logic sleep_go;
    logic ev_sleep;
    logic ev_wake;
    logic ev_rst;
    logic core_run;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic [2:0] next_irq_status;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] wake_set(input logic [2:0] m);
        case (m)
            slpmc_pkg::MODE_IDLE: wake_set = 8'hff; // [RULE12]
            slpmc_pkg::MODE_PDOWN: wake_set = slpmc_pkg::PDOWN_WAKE_SET;
            slpmc_pkg::MODE_PSAVE: wake_set = PSAVE_WAKE; // [RULE18]
            slpmc_pkg::MODE_STDBY: wake_set = STDBY_WAKE;
            slpmc_pkg::MODE_ESTDBY: wake_set = ESTDBY_WAKE;
            default: wake_set = slpmc_pkg::PDOWN_WAKE_SET;
        endcase
    endfunction

    function automatic logic mode_valid(input logic [2:0] m);
        mode_valid = (m == slpmc_pkg::MODE_IDLE)
            || (m == slpmc_pkg::MODE_PDOWN)
            || (m == slpmc_pkg::MODE_PSAVE)
            || (m == slpmc_pkg::MODE_STDBY)
            || (m == slpmc_pkg::MODE_ESTDBY); // [RULE1]
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            wake_sync1 <= 8'h00;
            wake_sync2 <= 8'h00;
            rst_sync1 <= 1'b0;
            rst_sync2 <= 1'b0;
        end else begin
            wake_sync1 <= WAKE_IRQ_IN;
            wake_sync2 <= wake_sync1;
            rst_sync1 <= RESET_REQ_IN;
            rst_sync2 <= rst_sync1;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign wr_stb = PSEL_IN && PENABLE_IN && PWRITE_IN;
    // read data is loaded in the setup cycle, zero wait states
    assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
    assign PREADY_OUT = 1'b1;

    always_comb begin
        case (PADDR_IN)
            slpmc_pkg::REG_CTRL,
            slpmc_pkg::REG_STATUS,
            slpmc_pkg::REG_PWR_RED,
            slpmc_pkg::REG_IRQ_STATUS,
            slpmc_pkg::REG_IRQ_MASK,
            slpmc_pkg::REG_WAKE_EN: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

    // ------------------------------------------------------------
    // write strobes per register
    // ------------------------------------------------------------
    // writes to read-only or unmapped words have no effect
    assign wr_ctrl = wr_stb && (PADDR_IN == slpmc_pkg::REG_CTRL);
    assign wr_pwr_red = wr_stb && (PADDR_IN == slpmc_pkg::REG_PWR_RED);
    assign wr_irq_mask = wr_stb && (PADDR_IN == slpmc_pkg::REG_IRQ_MASK);
    assign wr_wake_en = wr_stb && (PADDR_IN == slpmc_pkg::REG_WAKE_EN);
    assign wr_irq_status = wr_stb
        && (PADDR_IN == slpmc_pkg::REG_IRQ_STATUS);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sleep_enable <= slpmc_pkg::CTRL_RST[slpmc_pkg::CTRL_EN_BIT];
            mode_sel <= slpmc_pkg::CTRL_RST[3:1];
        end else if (wr_ctrl) begin
            sleep_enable <= PWDATA_IN[slpmc_pkg::CTRL_EN_BIT];
            mode_sel <= PWDATA_IN[3:1]; // [RULE17]
        end
    end

    // a set bit stops that peripheral's clock
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pwr_red <= slpmc_pkg::PWR_RED_RST[NUM_PERIPH-1:0];
        end else if (wr_pwr_red) begin
            pwr_red <= PWDATA_IN[NUM_PERIPH-1:0]; // [RULE15]
        end
    end

    // mask bits select which status bits drive the interrupt
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            irq_mask <= slpmc_pkg::IRQ_MASK_RST[2:0];
        end else if (wr_irq_mask) begin
            irq_mask <= PWDATA_IN[2:0];
        end
    end

    // wake enable filters the mode's wake set
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            wake_en <= slpmc_pkg::WAKE_EN_RST;
        end else if (wr_wake_en) begin
            wake_en <= PWDATA_IN[7:0];
        end
    end

    // ------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------
    // entry only from active, mode latched at the instruction
    assign sleep_go = (state == slpmc_pkg::ST_ACTIVE) && SLEEP_INSTR_IN
        && sleep_enable && mode_valid(mode_sel); // [RULE2] [RULE17]
    assign allowed = wake_set(active_mode) & wake_en; // [RULE4] [RULE14]
    assign wake_hit = |(wake_sync2 & allowed);

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state <= slpmc_pkg::ST_ACTIVE;
            active_mode <= slpmc_pkg::MODE_IDLE;
            halt_cnt <= 3'h0;
        end else begin
            case (state)
                slpmc_pkg::ST_ACTIVE: begin
                    if (sleep_go) begin
                        state <= slpmc_pkg::ST_SLEEP;
                        active_mode <= mode_sel; // [RULE17]
                    end
                end
                slpmc_pkg::ST_SLEEP: begin
                    // reset wake returns to active; core restarts [RULE9]
                    if (rst_sync2) begin
                        state <= slpmc_pkg::ST_ACTIVE; // [RULE10]
                    end else if (wake_hit) begin
                        state <= slpmc_pkg::ST_HALT; // [RULE3]
                        halt_cnt <= 3'(slpmc_pkg::HALT_CYCLES - 1);
                    end
                end
                slpmc_pkg::ST_HALT: begin
                    // stall before resuming execution [RULE7]
                    if (halt_cnt == 3'h0) begin
                        state <= slpmc_pkg::ST_ACTIVE; // [RULE5] [RULE6]
                    end else begin
                        halt_cnt <= halt_cnt - 3'h1;
                    end
                end
                default: state <= slpmc_pkg::ST_ACTIVE;
            endcase
        end
    end

    assign ev_sleep = sleep_go;
    assign ev_wake = (state == slpmc_pkg::ST_SLEEP) && !rst_sync2 && wake_hit;
    assign ev_rst = (state == slpmc_pkg::ST_SLEEP) && rst_sync2;

    // ------------------------------------------------------------
    // core halt and core clock
    // ------------------------------------------------------------
    // the core stops on the entry cycle itself
    assign core_run = (state == slpmc_pkg::ST_ACTIVE) && !sleep_go;

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            CORE_HALT_OUT <= 1'b0;
            CORE_CLK_EN_OUT <= 1'b1;
        end else begin
            // state is frozen by clock stop, never cleared [RULE8]
            CORE_HALT_OUT <= !core_run; // [RULE3]
            CORE_CLK_EN_OUT <= core_run; // [RULE11]
        end
    end

    // ------------------------------------------------------------
    // nonvolatile memory clock
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            NVM_CLK_EN_OUT <= 1'b1;
        end else begin
            // programming in flight keeps the memory clock [RULE11]
            NVM_CLK_EN_OUT <= core_run || NVM_BUSY_IN;
        end
    end

    // ------------------------------------------------------------
    // peripheral and real-time counter clocks
    // ------------------------------------------------------------
    // idle and halt keep peripherals clocked, deep sleep stops them
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            PERIPH_CLK_EN_OUT <= 1'b1;
            RTC_CLK_EN_OUT <= 1'b1;
            PERIPH_GATE_EN_OUT <= '1;
        end else if (state == slpmc_pkg::ST_SLEEP
                && active_mode != slpmc_pkg::MODE_IDLE) begin
            PERIPH_CLK_EN_OUT <= 1'b0; // [RULE13]
            PERIPH_GATE_EN_OUT <= '0;
            case (active_mode)
                slpmc_pkg::MODE_PSAVE: RTC_CLK_EN_OUT <= PSAVE_RTC_RUN;
                slpmc_pkg::MODE_ESTDBY: RTC_CLK_EN_OUT <= ESTDBY_RTC_RUN;
                default: RTC_CLK_EN_OUT <= 1'b0; // [RULE13] [RULE18]
            endcase
        end else begin
            PERIPH_CLK_EN_OUT <= 1'b1; // [RULE12]
            RTC_CLK_EN_OUT <= 1'b1;
            PERIPH_GATE_EN_OUT <= ~pwr_red; // [RULE15] [RULE16]
        end
    end

    // ------------------------------------------------------------
    // restart pulse
    // ------------------------------------------------------------
    // one-cycle pulse when a reset request ends a sleep
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            SYS_RESET_OUT <= 1'b0;
        end else begin
            SYS_RESET_OUT <= ev_rst; // [RULE9]
        end
    end

    // ------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ------------------------------------------------------------
    assign irq_set = {ev_rst, ev_wake, ev_sleep};

    // clear mask from a write to the status register
    always_comb begin
        irq_clr = 3'h0;
        if (wr_irq_status) begin
            irq_clr = PWDATA_IN[2:0];
        end
    end

    // an event in the clearing cycle stays set
    assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign IRQ_OUT = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (PADDR_IN)
                slpmc_pkg::REG_CTRL:
                    PRDATA_OUT <= {28'h0, mode_sel, sleep_enable};
                slpmc_pkg::REG_STATUS:
                    // debug view: pending wakes, latched mode, state
                    PRDATA_OUT <= {19'h0, wake_sync2, active_mode, state};
                slpmc_pkg::REG_PWR_RED:
                    PRDATA_OUT <= 32'(pwr_red);
                slpmc_pkg::REG_IRQ_STATUS:
                    PRDATA_OUT <= {29'h0, irq_status};
                slpmc_pkg::REG_IRQ_MASK:
                    PRDATA_OUT <= {29'h0, irq_mask};
                slpmc_pkg::REG_WAKE_EN:
                    PRDATA_OUT <= {24'h0, wake_en};
                default:
                    PRDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

endmodule // slpmc_top

// *** rtl/slpmc_pkg.sv ***
// package: register map, field layout, mode codes and timing constants
package slpmc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_PWR_RED = 12'h008;
    localparam logic [11:0] REG_IRQ_STATUS = 12'h00c;
    localparam logic [11:0] REG_IRQ_MASK = 12'h010;
    localparam logic [11:0] REG_WAKE_EN = 12'h014;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int MODE_W = 3;

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_SLEEP_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam int IRQ_RESET_WAKE_BIT = 2;

    // ------------------------------------------------------------
    // wake source indices
    // ------------------------------------------------------------
    localparam int WAKE_W = 8;
    localparam int WAKE_TWI_ADDR = 0;
    localparam int WAKE_PORT_ASYNC = 1;
    localparam int WAKE_USB_RESUME = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PWR_RED_RST = 32'h0000_0000;
    localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
    localparam logic [7:0] WAKE_EN_RST = 8'hff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int HALT_CYCLES = 4;
    localparam int HALT_CNT_W = 3;

    // ------------------------------------------------------------
    // sleep mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STDBY = 3'h6;
    localparam logic [2:0] MODE_ESTDBY = 3'h7;

    // power-down wake set: address match, async port, usb resume
    localparam logic [7:0] PDOWN_WAKE_SET = 8'h07;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_HALT
    } slpmc_state_e;

endpackage

// *** testbench/slpmc_chk.sv ***
// checker: port-level properties of the sleep controller
module slpmc_chk #(
    parameter int NUM_PERIPH = 16
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    // apb
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // core and clocks
    input wire logic SLEEP_INSTR_IN,
    input wire logic CORE_HALT_OUT,
    input wire logic CORE_CLK_EN_OUT,
    input wire logic PERIPH_CLK_EN_OUT,
    input wire logic RTC_CLK_EN_OUT,
    input wire logic [NUM_PERIPH-1:0] PERIPH_GATE_EN_OUT,
    input wire logic SYS_RESET_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    a_halt_cause: assert property ($rose(CORE_HALT_OUT) |->
        $past(SLEEP_INSTR_IN) || $past(SLEEP_INSTR_IN, 2))
        else $error("halt rose without a sleep instruction");
    a_core_clk_halt: assert property (
        !CORE_CLK_EN_OUT |-> CORE_HALT_OUT)
        else $error("core clock stopped while core runs");
    a_stall_four: assert property ($fell(CORE_HALT_OUT) &&
        !SYS_RESET_OUT && !$past(SYS_RESET_OUT) |-> $past(CORE_HALT_OUT, 5))
        else $error("core released too early after wake");
    a_stall_exact: assert property (
        $rose(PERIPH_CLK_EN_OUT) && CORE_HALT_OUT
        |-> CORE_HALT_OUT [*4] ##1 !CORE_HALT_OUT)
        else $error("halt stall not four cycles after deep wake");
    a_rtc_deep: assert property (!RTC_CLK_EN_OUT |->
        !CORE_CLK_EN_OUT && !PERIPH_CLK_EN_OUT)
        else $error("clock running while real-time clock stopped");
    a_gate_deep: assert property (
        !PERIPH_CLK_EN_OUT |-> PERIPH_GATE_EN_OUT == '0)
        else $error("peripheral gate open with peripheral clock off");
    a_apb_ready: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
        else $error("access phase without ready");
    a_err_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("slave error outside access phase");
    a_reset_pulse: assert property (SYS_RESET_OUT |=>
        !SYS_RESET_OUT && !CORE_HALT_OUT)
        else $error("restart pulse too long or core still halted");

    c_sleep: cover property ($rose(CORE_HALT_OUT));
    c_wake: cover property ($fell(CORE_HALT_OUT));
    c_restart: cover property (SYS_RESET_OUT);
    c_slverr: cover property (PSLVERR_OUT);
endmodule // slpmc_chk

bind slpmc_top slpmc_chk #(.NUM_PERIPH(NUM_PERIPH)) u_chk (
    .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .SLEEP_INSTR_IN(SLEEP_INSTR_IN),
    .CORE_HALT_OUT(CORE_HALT_OUT), .CORE_CLK_EN_OUT(CORE_CLK_EN_OUT),
    .PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT), .RTC_CLK_EN_OUT(RTC_CLK_EN_OUT),
    .PERIPH_GATE_EN_OUT(PERIPH_GATE_EN_OUT), .SYS_RESET_OUT(SYS_RESET_OUT));

// *** testbench/slpmc_core_mdl.sv ***
// core model: issues the sleep instruction and memory programming
module slpmc_core_mdl (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // test control
    input wire logic exec_sleep_in,
    input wire logic nvm_prog_in,
    // controller side
    input wire logic halt_in,
    output logic sleep_instr_out,
    output logic nvm_busy_out
);
    // sleep instruction only runs while fetching
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_instr_out <= 1'b0;
        end else begin
            sleep_instr_out <= exec_sleep_in && !halt_in;
        end
    end
    assign nvm_busy_out = nvm_prog_in;
endmodule // slpmc_core_mdl

// *** testbench/slpmc_top_test.sv ***
// testbench: register, sleep and wake sequences for the controller
module slpmc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 16;
    logic clk, rst_n, psel, penable, pwrite, go, prog, rst_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] wake_irq;
    logic pready, pslverr, sleep_i, busy, halt, cclk, nclk, pclk, rclk;
    logic sysrst, irq;
    logic [NP-1:0] gate;
    logic [2:0] deep [4];
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    slpmc_top #(.NUM_PERIPH(NP)) uut (
        .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .SLEEP_INSTR_IN(sleep_i), .NVM_BUSY_IN(busy),
        .CORE_HALT_OUT(halt), .WAKE_IRQ_IN(wake_irq), .RESET_REQ_IN(rst_req),
        .CORE_CLK_EN_OUT(cclk), .NVM_CLK_EN_OUT(nclk),
        .PERIPH_CLK_EN_OUT(pclk), .RTC_CLK_EN_OUT(rclk),
        .PERIPH_GATE_EN_OUT(gate), .SYS_RESET_OUT(sysrst), .IRQ_OUT(irq));
    slpmc_core_mdl core (.clk_in(clk), .rst_n_in(rst_n), .exec_sleep_in(go),
        .nvm_prog_in(prog), .halt_in(halt), .sleep_instr_out(sleep_i),
        .nvm_busy_out(busy));

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string w, input logic [31:0] s, x);
        checks_done++;
        if (s !== x) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string w, input logic [11:0] a, logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(w, q, x);
    endtask
    task automatic do_sleep(input logic [2:0] m, input logic en);
        wr(slpmc_pkg::REG_CTRL, {28'h0, m, en});
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wake(input int b, output int n);
        @(posedge clk) wake_irq <= 8'h01 << b;
        n = 0;
        while (halt !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        wake_irq <= 8'h00;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n;
        logic [31:0] q;
        logic e;
        {clk, rst_n, psel, penable, pwrite, go, prog, rst_req} = '0;
        paddr = '0;
        pwdata = '0;
        wake_irq = '0;
        deep = '{slpmc_pkg::MODE_PDOWN, slpmc_pkg::MODE_PSAVE,
                 slpmc_pkg::MODE_STDBY, slpmc_pkg::MODE_ESTDBY};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd("ctrl", slpmc_pkg::REG_CTRL, slpmc_pkg::CTRL_RST);
        rd("pwr_red", slpmc_pkg::REG_PWR_RED, slpmc_pkg::PWR_RED_RST);
        rd("irq_mask", slpmc_pkg::REG_IRQ_MASK, slpmc_pkg::IRQ_MASK_RST);
        rd("wake_en", slpmc_pkg::REG_WAKE_EN, {24'h0, slpmc_pkg::WAKE_EN_RST});
        apb(1'b0, 12'h0fc, 32'h0, q, e);
        chk("slverr", {31'h0, e}, 32'h1);
        chk("unmapped", q, 32'h0);
        wr(slpmc_pkg::REG_PWR_RED, 32'h5);
        repeat (2) @(posedge clk);
        chk("gate", {16'h0, gate}, {16'h0, ~16'h0005});
        prog <= 1'b1;
        do_sleep(slpmc_pkg::MODE_IDLE, 1'b1);
        chk("nvm_busy_clk", {31'h0, nclk}, 32'h1);
        prog <= 1'b0;
        repeat (4) @(posedge clk);
        chk("idle_halt", {31'h0, halt}, 32'h1);
        chk("idle_core", {30'h0, cclk, nclk}, 32'h0);
        chk("idle_periph", {31'h0, pclk}, 32'h1);
        chk("idle_gate", {16'h0, gate}, {16'h0, ~16'h0005});
        wake(5, n);
        chk("stall", {31'h0, n >= 5 && n < 100}, 32'h1);
        chk("clk_back", {29'h0, cclk, pclk, rclk}, 32'h7);
        rd("kept", slpmc_pkg::REG_PWR_RED, 32'h5);
        rd("status", slpmc_pkg::REG_IRQ_STATUS, 32'h3);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(slpmc_pkg::REG_IRQ_MASK, 32'h2);
        @(posedge clk);
        chk("irq_on", {31'h0, irq}, 32'h1);
        wr(slpmc_pkg::REG_IRQ_STATUS, 32'h7);
        @(posedge clk);
        chk("irq_off", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            do_sleep(deep[i], 1'b1);
            chk("deep_clk", {30'h0, rclk, pclk}, 32'h0);
            @(posedge clk) wake_irq <= 8'h20;
            repeat (20) @(posedge clk);
            chk("blocked", {31'h0, halt}, 32'h1);
            wake(i % 3, n);
            chk("deep_wake", {31'h0, halt}, 32'h0);
        end
        wr(slpmc_pkg::REG_WAKE_EN, 32'h0000_00fe);
        do_sleep(slpmc_pkg::MODE_PDOWN, 1'b1);
        wake(0, n);
        chk("wake_en_off", {31'h0, halt}, 32'h1);
        wake(1, n);
        chk("wake_en_on", {31'h0, halt}, 32'h0);
        do_sleep(slpmc_pkg::MODE_PDOWN, 1'b0);
        chk("disabled", {31'h0, halt}, 32'h0);
        do_sleep(3'h1, 1'b1);
        chk("bad_mode", {31'h0, halt}, 32'h0);
        do_sleep(slpmc_pkg::MODE_PDOWN, 1'b1);
        @(posedge clk) rst_req <= 1'b1;
        n = 0;
        while (sysrst !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("restart", {31'h0, sysrst}, 32'h1);
        rst_req <= 1'b0;
        repeat (2) @(posedge clk);
        chk("restart_run", {31'h0, halt}, 32'h0);
        rd("rst_status", slpmc_pkg::REG_IRQ_STATUS, 32'h7);
        rd("state", slpmc_pkg::REG_STATUS,
           {27'h0, slpmc_pkg::MODE_PDOWN, 2'h0});
        test_done();
    end
endmodule // slpmc_top_test
